// ==== bench/ssg_ram_model.sv ====
// internal stack RAM model answering the guard's accesses
`timescale 1ns/1ps
module ssg_ram_model (
  input  wire logic              clock_i,
  input  wire ssg_pkg::ssg_ram_t ram_i,
  output logic [15:0]            rd_data_o
);
  logic [15:0] mem [0:511];
  logic [15:0] last_r;
  logic        vld_r;

  initial begin
    vld_r = 1'b0;
    last_r = 16'h0000;
    foreach (mem[i]) mem[i] = 16'hA5A5 ^ 16'(i);
  end

  always @(posedge clock_i) begin
    vld_r <= ram_i.en && !ram_i.we;
    if (ram_i.en && ram_i.we) begin
      if (ram_i.be[0]) mem[ram_i.addr[9:1]][7:0] <= ram_i.wdata[7:0];
      if (ram_i.be[1]) mem[ram_i.addr[9:1]][15:8] <= ram_i.wdata[15:8];
    end
    if (ram_i.en && !ram_i.we) begin
      last_r <= mem[ram_i.addr[9:1]];
    end
  end

  // released data lines show the inverse of the last word
  assign rd_data_o = vld_r ? last_r : ~last_r;
endmodule

// ==== bench/system_stack_guard_tb_top.sv ====
// self-checking bench for the system stack guard
`timescale 1ns/1ps
module system_stack_guard_tb_top;
  logic              clock_i;
  logic              rst_n_i;
  ssg_pkg::ssg_req_t req;
  logic [1:0]        sel;
  logic [15:0]       rd_data;
  ssg_pkg::ssg_ram_t ram;
  ssg_pkg::ssg_gpr_t gpr;
  ssg_pkg::ssg_ret_t pop;
  logic [15:0]       sp, ovl, unl, cp, ip;
  logic              ovf, unf, ill;
  int                err_count = 0;
  int                n_tests = 0;
  int                cyc = 0;

  ssg_stack_guard u_ssg_stack_guard (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req),
    .stack_size_sel_i(sel), .rd_data_i(rd_data), .ram_o(ram),
    .gpr_o(gpr), .pop_o(pop), .system_stack_top_pointer_o(sp),
    .stack_overflow_limit_o(ovl), .stack_underflow_limit_o(unl),
    .register_bank_base_pointer_o(cp), .code_offset_pointer_o(ip),
    .ovf_trap_o(ovf), .unf_trap_o(unf), .illegal_idx_o(ill)
  );

  ssg_ram_model u_ssg_ram_model (
    .clock_i(clock_i), .ram_i(ram), .rd_data_o(rd_data)
  );

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one request taken at the next edge; returns in the answer cycle
  task automatic go(ssg_pkg::ssg_op_t op, logic [15:0] opd,
                    logic [15:0] ptr = 16'h0000, logic [3:0] gi = 4'h0,
                    logic by = 1'b0);
    @(posedge clock_i);
    req <= '{valid: 1'b1, op: op, operand: opd, ptr: ptr, gidx: gi,
             byte_acc: by};
    @(posedge clock_i);
    req.valid <= 1'b0;
    #1;
  endtask

  // read data lands two edges after the answer cycle
  task automatic rd3();
    repeat (2) @(posedge clock_i);
    #1;
  endtask

  task automatic t_push_pop();
    go(ssg_pkg::OP_PUSH, 16'h1234);
    chk("push sp", sp, 16'hFBFE);
    chk("push addr", ram.addr, 16'hFBFE);
    chk("push data", ram.wdata, 16'h1234);
    chk("push ctl", 16'({ram.en, ram.we, ram.sys}), 16'h0007);
    chk("push be", 16'(ram.be), 16'(ssg_pkg::BE_WORD));
    chk("push ovf", 16'(ovf), 16'h0000);
    go(ssg_pkg::OP_POP, 16'h0000);
    chk("pop sp", sp, 16'hFC00);
    chk("pop addr", ram.addr, 16'hFBFE);
    chk("pop ctl", 16'({ram.en, ram.we, ram.sys}), 16'h0005);
    chk("pop unf edge", 16'(unf), 16'h0000);
    rd3();
    chk("pop valid", 16'(pop.valid), 16'h0001);
    chk("pop data", pop.data, 16'h1234);
    go(ssg_pkg::OP_POP, 16'h0000);
    chk("pop2 sp", sp, 16'hFC02);
    chk("pop2 unf", 16'(unf), 16'h0001);
    go(ssg_pkg::OP_MOV_SP, 16'hFC00);
  endtask

  task automatic t_wrap();
    logic [15:0] m;
    for (int s = 0; s < 4; s++) begin
      @(posedge clock_i) sel <= s[1:0];
      go(ssg_pkg::OP_MOV_SP, 16'hFA01);
      chk("mov sp", sp, 16'hFA00);
      chk("mov ovf", 16'(ovf), 16'h0000);
      go(ssg_pkg::OP_PUSH, 16'h00C0 + 16'(s));
      m = (16'h0040 << s) - 16'h0001;
      m = (16'hFA00 & ~m) | (16'hF9FE & m);
      chk("wrap addr", ram.addr, m);
      chk("wrap sp", sp, 16'hF9FE);
      chk("wrap ovf", 16'(ovf), 16'h0001);
    end
    @(posedge clock_i) sel <= 2'h3;
    go(ssg_pkg::OP_MOV_SP, 16'hFC00);
  endtask

  task automatic t_limits();
    go(ssg_pkg::OP_MOV_OVL, 16'hFB00);
    go(ssg_pkg::OP_MOV_UNL, 16'hFB00);
    chk("ovl", ovl, 16'hFB00);
    chk("unl", unl, 16'hFB00);
    go(ssg_pkg::OP_MOV_SP, 16'hFB02);
    chk("mov unf", 16'(unf), 16'h0000);
    go(ssg_pkg::OP_SUB_SP, 16'h0004);
    chk("sub sp", sp, 16'hFAFE);
    chk("sub ovf", 16'(ovf), 16'h0001);
    go(ssg_pkg::OP_ADD_SP, 16'h0004);
    chk("add sp", sp, 16'hFB02);
    chk("add unf", 16'(unf), 16'h0001);
    go(ssg_pkg::OP_SUB_SP, 16'h0002);
    chk("edge ovf", 16'(ovf), 16'h0000);
    go(ssg_pkg::OP_MOV_OVL, 16'hFA00);
    go(ssg_pkg::OP_MOV_UNL, 16'hFC00);
    go(ssg_pkg::OP_MOV_SP, 16'hFC00);
  endtask

  task automatic t_call_ret();
    go(ssg_pkg::OP_CALL, 16'h0100);
    chk("call1 push", ram.wdata, 16'h0000);
    chk("call1 ip", ip, 16'h0100);
    go(ssg_pkg::OP_PUSH, 16'hBEEF);
    go(ssg_pkg::OP_CALL, 16'h0200);
    chk("call2 push", ram.wdata, 16'h0100);
    go(ssg_pkg::OP_RET, 16'h0000);
    rd3();
    chk("ret2 ip", ip, 16'h0100);
    go(ssg_pkg::OP_POP, 16'h0000);
    go(ssg_pkg::OP_RET, 16'h0000);
    rd3();
    chk("ret1 ip", ip, 16'h0000);
    chk("ret sp", sp, 16'hFC00);
  endtask

  task automatic t_bank();
    go(ssg_pkg::OP_SWITCH_CONTEXT_OP, 16'hF600);
    chk("switch_context_op cp", cp, 16'hF600);
    chk("switch_context_op save", ram.wdata, 16'hFC00);
    chk("switch_context_op addr", ram.addr, 16'hFBFE);
    go(ssg_pkg::OP_POP_CP, 16'h0000);
    rd3();
    chk("restore cp", cp, 16'hFC00);
  endtask

  task automatic t_user();
    go(ssg_pkg::OP_USR_PREDEC, 16'h5A5A, 16'h2000, 4'hF);
    chk("pre addr", ram.addr, 16'h1FFE);
    chk("pre data", ram.wdata, 16'h5A5A);
    chk("pre ptr", gpr.value, 16'h1FFE);
    chk("gpr addr", gpr.addr, 16'hFC1E);
    chk("gpr idx", 16'(gpr.idx), 16'h000F);
    chk("gpr en", 16'(gpr.en), 16'h0001);
    chk("pre trap", 16'(ovf | unf), 16'h0000);
    go(ssg_pkg::OP_USR_POSTINC, 16'h0000, 16'h1FFE, 4'hF);
    chk("post addr", ram.addr, 16'h1FFE);
    chk("post ptr", gpr.value, 16'h2000);
    chk("post trap", 16'(ovf | unf), 16'h0000);
    rd3();
    chk("post data", pop.data, 16'h5A5A);
    go(ssg_pkg::OP_IDX_POSTINC, 16'h0000, 16'h1FFE, 4'h4);
    chk("idx4 refused", 16'(ill), 16'h0001);
    chk("idx4 ram", 16'(ram.en), 16'h0000);
    go(ssg_pkg::OP_IDX_POSTINC, 16'h0000, 16'h1FFE, 4'h3);
    chk("idx3 ok", 16'(ill), 16'h0000);
    chk("idx3 ptr", gpr.value, 16'h2000);
    go(ssg_pkg::OP_USR_PREDEC, 16'h0077, 16'h2000, 4'h1, 1'b1);
    chk("byte ptr", gpr.value, 16'h1FFF);
    chk("byte lane", 16'(ram.be), 16'(ssg_pkg::BE_HI));
    go(ssg_pkg::OP_USR_POSTINC, 16'h0000, 16'h1FFF, 4'h1, 1'b1);
    chk("bpop ptr", gpr.value, 16'h2000);
    rd3();
    chk("bpop hi", pop.data, 16'h0077);
    go(ssg_pkg::OP_USR_POSTINC, 16'h0000, 16'h1FFE, 4'h1, 1'b1);
    chk("bpop ptr2", gpr.value, 16'h1FFF);
    rd3();
    chk("bpop lo", pop.data, 16'h005A);
  endtask

  initial begin
    rst_n_i = 1'b0;
    sel = 2'h3;
    req = '0;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk("rst sp", sp, ssg_pkg::SP_RST);
    chk("rst ovl", ovl, ssg_pkg::OVL_RST);
    chk("rst unl", unl, ssg_pkg::UNL_RST);
    // start-up limits: bottom of stack, minus 256 words, plus 6 reserved
    go(ssg_pkg::OP_MOV_UNL, 16'hFC00);
    go(ssg_pkg::OP_MOV_OVL, 16'hFC00 - 16'h0200 + 16'h000C);
    chk("init ovl", ovl, 16'hFA0C);
    chk("init unl", unl, 16'hFC00);
    t_push_pop();
    t_wrap();
    t_limits();
    t_call_ret();
    t_user();
    t_bank();
    wrap_up();
  end
endmodule

// ==== hdl/ssg_limit_check.sv ====
// overflow and underflow comparison on the updated stack pointer
`timescale 1ns/1ps
module ssg_limit_check (
  input  wire logic [15:0] new_sp_i,
  input  wire logic [15:0] ovl_i,
  input  wire logic [15:0] unl_i,
  input  wire logic        dec_i,
  input  wire logic        inc_i,
  output logic             ovf_o,
  output logic             unf_o
);
  assign ovf_o = dec_i && (new_sp_i < ovl_i);
  assign unf_o = inc_i && (new_sp_i > unl_i);
endmodule

// ==== hdl/ssg_pkg.sv ====
// shared constants and carriers for the system stack guard
package ssg_pkg;

  localparam int unsigned DATA_W       = 16;
  localparam int unsigned GIDX_W       = 4;
  localparam int unsigned SIZE_SEL_W   = 2;
  // lowest masked bit count: 32 words = 64 bytes -> bits [5:0]
  localparam int unsigned MASK_MSB_MIN = 5;
  localparam int unsigned MASK_MSB_MAX = 8;

  localparam logic [15:0] STACK_BASE   = 16'hFA00;
  localparam logic [15:0] STACK_TOP    = 16'hFBFE;
  localparam logic [15:0] SP_RST       = 16'hFC00;
  localparam logic [15:0] OVL_RST      = 16'hFA00;
  localparam logic [15:0] UNL_RST      = 16'hFC00;
  localparam logic [15:0] CP_RST       = 16'hFC00;
  localparam logic [15:0] IP_RST       = 16'h0000;
  localparam logic [15:0] WORD_STEP    = 16'h0002;
  localparam logic [15:0] BYTE_STEP    = 16'h0001;
  localparam logic [3:0]  USR_IDX_MAX  = 4'h3;
  localparam logic [1:0]  BE_WORD      = 2'h3;
  localparam logic [1:0]  BE_LO        = 2'h1;
  localparam logic [1:0]  BE_HI        = 2'h2;

  typedef enum logic [3:0] {
    OP_NONE, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_SUB_SP, OP_ADD_SP,
    OP_MOV_SP, OP_MOV_OVL, OP_MOV_UNL, OP_SWITCH_CONTEXT_OP, OP_POP_CP,
    OP_USR_PREDEC, OP_USR_POSTINC, OP_IDX_POSTINC
  } ssg_op_t;

  typedef enum logic [1:0] {TGT_NONE, TGT_EXT, TGT_IP, TGT_CP} ssg_tgt_t;

  typedef struct packed {
    logic        valid;
    ssg_op_t     op;
    logic [15:0] operand;
    logic [15:0] ptr;
    logic [3:0]  gidx;
    logic        byte_acc;
  } ssg_req_t;

  typedef struct packed {
    logic        en;
    logic        we;
    logic        sys;
    logic [1:0]  be;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ssg_ram_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [15:0] addr;
    logic [15:0] value;
  } ssg_gpr_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } ssg_ret_t;

endpackage

// ==== hdl/ssg_stack_addr.sv ====
// circular internal stack address from a virtual stack pointer
`timescale 1ns/1ps
module ssg_stack_addr (
  input  wire logic [15:0] sp_i,
  input  wire logic [1:0]  size_sel_i,
  output logic      [15:0] addr_o
);
  logic [3:0] msb;

  assign msb = 4'(ssg_pkg::MASK_MSB_MIN) + {2'h0, size_sel_i};

  // low bits follow the pointer, upper bits fixed to the stack area
  for (genvar i = 0; i < 16; i++) begin : g_bit
    if (i < ssg_pkg::MASK_MSB_MIN + 1) begin : g_low
      assign addr_o[i] = (i == 0) ? 1'b0 : sp_i[i];
    end else if (i <= ssg_pkg::MASK_MSB_MAX) begin : g_mid
      assign addr_o[i] = (4'(i) <= msb) ? sp_i[i]
                                        : ssg_pkg::STACK_BASE[i];
    end else begin : g_high
      assign addr_o[i] = ssg_pkg::STACK_BASE[i];
    end
  end
endmodule

// ==== hdl/ssg_stack_guard.sv ====
// system stack guard: pointers, limit traps, stack RAM access
// What this block does
// - pushes decrement the stack top pointer, pops increment it.
// - stack holds words only; pointer bit zero always reads zero.
// - call, push, subtract check updated pointer below overflow limit.
// - return, pop, add check updated pointer above underflow limit.
// - moving a value into the pointer never compares nor traps.
// - RAM address masks pointer upper bits; 32 to 256 word sizes.
// - stepping below the stack area wraps to its top.
// - pointer and limits keep full virtual addresses; only RAM is masked.
// - system and user stacks grow toward lower addresses.
// - user stack pointers never raise traps.
// - post-increment indirect reads at pointer, then advances it.
// - pre-decrement indirect steps pointer down, then writes there.
// - index post-increment pop accepts only registers zero to three.
// - a register bank maps at most 16 registers from its base pointer.
// - context switch saves old bank pointer, loads new one in one cycle.
// - call pushes the code offset pointer, return pops it back.
`timescale 1ns/1ps
module ssg_stack_guard #(
  parameter int unsigned DATA_W = ssg_pkg::DATA_W
) (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire ssg_pkg::ssg_req_t req_i,
  input  wire logic [1:0]        stack_size_sel_i,
  input  wire logic [15:0]       rd_data_i,
  output ssg_pkg::ssg_ram_t      ram_o,
  output ssg_pkg::ssg_gpr_t      gpr_o,
  output ssg_pkg::ssg_ret_t      pop_o,
  output logic [15:0]            system_stack_top_pointer_o,
  output logic [15:0]            stack_overflow_limit_o,
  output logic [15:0]            stack_underflow_limit_o,
  output logic [15:0]            register_bank_base_pointer_o,
  output logic [15:0]            code_offset_pointer_o,
  output logic                   ovf_trap_o,
  output logic                   unf_trap_o,
  output logic                   illegal_idx_o
);

  if (DATA_W != 16) begin : g_chk
    $error("ssg_stack_guard supports a 16-bit data path only");
  end

  // core state
  logic [15:0]       sp_r, sp_nxt, ovl_r, ovl_nxt, unl_r, unl_nxt;
  logic [15:0]       cp_r, cp_nxt, ip_r, ip_nxt;
  ssg_pkg::ssg_ram_t ram_r, ram_nxt;
  ssg_pkg::ssg_gpr_t gpr_r, gpr_nxt;
  logic              ovf_r, ovf_nxt, unf_r, unf_nxt, ill_r, ill_nxt;
  // read return pipeline
  ssg_pkg::ssg_tgt_t tgt1_r, tgt1_nxt, tgt2_r, tgt2_nxt;
  logic              lane1_r, lane1_nxt, lane2_r, lane2_nxt;
  logic              byte1_r, byte1_nxt, byte2_r, byte2_nxt;
  ssg_pkg::ssg_ret_t pop_r, pop_nxt;

  logic [15:0] sp_dn, sp_up, sp_amt, step, new_ptr;
  logic [15:0] push_addr, pop_addr, rd_val;
  logic        dec, inc;
  ssg_pkg::ssg_op_t op;

  assign op     = req_i.valid ? req_i.op : ssg_pkg::OP_NONE;
  assign sp_dn  = sp_r - ssg_pkg::WORD_STEP;
  assign sp_up  = sp_r + ssg_pkg::WORD_STEP;
  assign sp_amt = {req_i.operand[15:1], 1'b0};
  assign step   = req_i.byte_acc ? ssg_pkg::BYTE_STEP
                                 : ssg_pkg::WORD_STEP;

  // push goes to masked new pointer, pop reads at masked old pointer
  ssg_stack_addr u_push_addr (
    .sp_i       (sp_dn),
    .size_sel_i (stack_size_sel_i),
    .addr_o     (push_addr)
  );

  ssg_stack_addr u_pop_addr (
    .sp_i       (sp_r),
    .size_sel_i (stack_size_sel_i),
    .addr_o     (pop_addr)
  );

  ssg_limit_check u_limit (
    .new_sp_i (sp_nxt),
    .ovl_i    (ovl_r),
    .unl_i    (unl_r),
    .dec_i    (dec),
    .inc_i    (inc),
    .ovf_o    (ovf_nxt),
    .unf_o    (unf_nxt)
  );

  always_comb begin
    sp_nxt   = sp_r;
    ovl_nxt  = ovl_r;
    unl_nxt  = unl_r;
    cp_nxt   = cp_r;
    ip_nxt   = ip_r;
    ram_nxt  = '0;
    gpr_nxt  = '0;
    ill_nxt  = 1'b0;
    dec      = 1'b0;
    inc      = 1'b0;
    new_ptr  = req_i.ptr;
    case (op)
      ssg_pkg::OP_PUSH, ssg_pkg::OP_CALL, ssg_pkg::OP_SWITCH_CONTEXT_OP: begin
        sp_nxt        = sp_dn;
        dec           = 1'b1;
        ram_nxt.en    = 1'b1;
        ram_nxt.we    = 1'b1;
        ram_nxt.sys   = 1'b1;
        ram_nxt.be    = ssg_pkg::BE_WORD;
        ram_nxt.addr  = push_addr;
        ram_nxt.wdata = req_i.operand;
        if (op == ssg_pkg::OP_CALL) begin
          ram_nxt.wdata = ip_r;
          ip_nxt        = req_i.operand;
        end else if (op == ssg_pkg::OP_SWITCH_CONTEXT_OP) begin
          ram_nxt.wdata = cp_r;
          cp_nxt        = sp_amt;
        end
      end
      ssg_pkg::OP_POP, ssg_pkg::OP_RET, ssg_pkg::OP_POP_CP: begin
        sp_nxt       = sp_up;
        inc          = 1'b1;
        ram_nxt.en   = 1'b1;
        ram_nxt.sys  = 1'b1;
        ram_nxt.be   = ssg_pkg::BE_WORD;
        ram_nxt.addr = pop_addr;
      end
      ssg_pkg::OP_SUB_SP: begin
        sp_nxt = sp_r - sp_amt;
        dec    = 1'b1;
      end
      ssg_pkg::OP_ADD_SP: begin
        sp_nxt = sp_r + sp_amt;
        inc    = 1'b1;
      end
      ssg_pkg::OP_MOV_SP:  sp_nxt  = sp_amt;
      ssg_pkg::OP_MOV_OVL: ovl_nxt = sp_amt;
      ssg_pkg::OP_MOV_UNL: unl_nxt = sp_amt;
      ssg_pkg::OP_USR_PREDEC: begin
        new_ptr       = req_i.ptr - step;
        ram_nxt.en    = 1'b1;
        ram_nxt.we    = 1'b1;
        ram_nxt.addr  = new_ptr;
        ram_nxt.be    = !req_i.byte_acc ? ssg_pkg::BE_WORD
                      : new_ptr[0] ? ssg_pkg::BE_HI : ssg_pkg::BE_LO;
        ram_nxt.wdata = req_i.byte_acc ? {2{req_i.operand[7:0]}}
                                       : req_i.operand;
        gpr_nxt.en    = 1'b1;
      end
      ssg_pkg::OP_USR_POSTINC, ssg_pkg::OP_IDX_POSTINC: begin
        if (op == ssg_pkg::OP_IDX_POSTINC
            && req_i.gidx > ssg_pkg::USR_IDX_MAX) begin
          ill_nxt = 1'b1;
        end else begin
          new_ptr      = req_i.ptr + step;
          ram_nxt.en   = 1'b1;
          ram_nxt.addr = req_i.ptr;
          ram_nxt.be   = !req_i.byte_acc ? ssg_pkg::BE_WORD
                       : req_i.ptr[0] ? ssg_pkg::BE_HI : ssg_pkg::BE_LO;
          gpr_nxt.en   = 1'b1;
        end
      end
      default: ;
    endcase
    gpr_nxt.idx   = req_i.gidx;
    gpr_nxt.addr  = cp_r + {11'h000, req_i.gidx, 1'b0};
    gpr_nxt.value = new_ptr;
    if (!gpr_nxt.en) begin
      gpr_nxt = '0;
    end
    // returned word lands two cycles after the read is issued
    if (tgt2_r == ssg_pkg::TGT_IP) begin
      ip_nxt = rd_data_i;
    end
    if (tgt2_r == ssg_pkg::TGT_CP) begin
      cp_nxt = rd_data_i;
    end
    sp_nxt[0]  = 1'b0;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_r  <= ssg_pkg::SP_RST;
      ovl_r <= ssg_pkg::OVL_RST;
      unl_r <= ssg_pkg::UNL_RST;
      cp_r  <= ssg_pkg::CP_RST;
      ip_r  <= ssg_pkg::IP_RST;
      ram_r <= '0;
      gpr_r <= '0;
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
      ill_r <= 1'b0;
    end else begin
      sp_r  <= sp_nxt;
      ovl_r <= ovl_nxt;
      unl_r <= unl_nxt;
      cp_r  <= cp_nxt;
      ip_r  <= ip_nxt;
      ram_r <= ram_nxt;
      gpr_r <= gpr_nxt;
      ovf_r <= ovf_nxt;
      unf_r <= unf_nxt;
      ill_r <= ill_nxt;
    end
  end

  always_comb begin
    tgt1_nxt  = ssg_pkg::TGT_NONE;
    lane1_nxt = 1'b0;
    byte1_nxt = 1'b0;
    case (op)
      ssg_pkg::OP_POP:    tgt1_nxt = ssg_pkg::TGT_EXT;
      ssg_pkg::OP_RET:    tgt1_nxt = ssg_pkg::TGT_IP;
      ssg_pkg::OP_POP_CP: tgt1_nxt = ssg_pkg::TGT_CP;
      ssg_pkg::OP_USR_POSTINC, ssg_pkg::OP_IDX_POSTINC: begin
        if (!ill_nxt) begin
          tgt1_nxt  = ssg_pkg::TGT_EXT;
          lane1_nxt = req_i.ptr[0];
          byte1_nxt = req_i.byte_acc;
        end
      end
      default: ;
    endcase
    tgt2_nxt  = tgt1_r;
    lane2_nxt = lane1_r;
    byte2_nxt = byte1_r;
    rd_val    = !byte2_r ? rd_data_i
              : lane2_r ? {8'h00, rd_data_i[15:8]}
                        : {8'h00, rd_data_i[7:0]};
    pop_nxt.valid = (tgt2_r == ssg_pkg::TGT_EXT);
    pop_nxt.data  = pop_nxt.valid ? rd_val : 16'h0000;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgt1_r  <= ssg_pkg::TGT_NONE;
      tgt2_r  <= ssg_pkg::TGT_NONE;
      lane1_r <= 1'b0;
      lane2_r <= 1'b0;
      byte1_r <= 1'b0;
      byte2_r <= 1'b0;
      pop_r   <= '0;
    end else begin
      tgt1_r  <= tgt1_nxt;
      tgt2_r  <= tgt2_nxt;
      lane1_r <= lane1_nxt;
      lane2_r <= lane2_nxt;
      byte1_r <= byte1_nxt;
      byte2_r <= byte2_nxt;
      pop_r   <= pop_nxt;
    end
  end

  assign ram_o                        = ram_r;
  assign gpr_o                        = gpr_r;
  assign pop_o                        = pop_r;
  assign system_stack_top_pointer_o   = sp_r;
  assign stack_overflow_limit_o       = ovl_r;
  assign stack_underflow_limit_o      = unl_r;
  assign register_bank_base_pointer_o = cp_r;
  assign code_offset_pointer_o        = ip_r;
  assign ovf_trap_o                   = ovf_r;
  assign unf_trap_o                   = unf_r;
  assign illegal_idx_o                = ill_r;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  logic is_dec, is_inc, is_user;
  assign is_dec  = op inside {ssg_pkg::OP_PUSH, ssg_pkg::OP_CALL,
                              ssg_pkg::OP_SWITCH_CONTEXT_OP, ssg_pkg::OP_SUB_SP};
  assign is_inc  = op inside {ssg_pkg::OP_POP, ssg_pkg::OP_RET,
                              ssg_pkg::OP_POP_CP, ssg_pkg::OP_ADD_SP};
  assign is_user = op inside {ssg_pkg::OP_USR_PREDEC,
                              ssg_pkg::OP_USR_POSTINC,
                              ssg_pkg::OP_IDX_POSTINC};

  sequence s_ret_req;
    op == ssg_pkg::OP_RET;
  endsequence
  sequence s_ret_load;
    ##3 code_offset_pointer_o == $past(rd_data_i);
  endsequence

  a_push_step: assert property (
    op == ssg_pkg::OP_PUSH |=>
      system_stack_top_pointer_o == $past(sp_r) - 16'h0002)
    else $error("push did not step pointer down by two");
  a_sp_even: assert property (
    system_stack_top_pointer_o[0] == 1'b0)
    else $error("stack pointer odd");
  a_ovf_trap: assert property (
    is_dec |=> ovf_trap_o == (system_stack_top_pointer_o
                              < stack_overflow_limit_o))
    else $error("overflow trap wrong after decrement");
  a_unf_trap: assert property (
    is_inc |=> unf_trap_o == (system_stack_top_pointer_o
                              > stack_underflow_limit_o))
    else $error("underflow trap wrong after increment");
  a_mov_quiet: assert property (
    op == ssg_pkg::OP_MOV_SP |=> !ovf_trap_o && !unf_trap_o)
    else $error("move into pointer raised a trap");
  a_ram_window: assert property (
    ram_o.en && ram_o.sys |-> ram_o.addr >= ssg_pkg::STACK_BASE
                           && ram_o.addr <= ssg_pkg::STACK_TOP)
    else $error("stack access outside internal stack area");
  a_user_quiet: assert property (
    is_user |=> !ovf_trap_o && !unf_trap_o)
    else $error("user stack raised a trap");
  a_predec_wr: assert property (
    op == ssg_pkg::OP_USR_PREDEC && !req_i.byte_acc |=>
      ram_o.we && ram_o.addr == $past(req_i.ptr) - 16'h0002
      && gpr_o.value == ram_o.addr)
    else $error("pre-decrement write misplaced");
  a_idx_guard: assert property (
    op == ssg_pkg::OP_IDX_POSTINC && req_i.gidx > 4'h3 |=>
      illegal_idx_o && !gpr_o.en && !ram_o.en)
    else $error("index pop accepted a high register");
  a_switch_context_op_swap: assert property (
    op == ssg_pkg::OP_SWITCH_CONTEXT_OP |=> ram_o.we
      && ram_o.wdata == $past(cp_r)
      && register_bank_base_pointer_o == $past(sp_amt))
    else $error("context switch did not save and load");
  a_ret_ip: assert property (
    s_ret_req |-> s_ret_load)
    else $error("return did not restore code offset");

endmodule
